// *** core/rtp_reset_seq.sv ***
// Reset sequencer, phase generator and reset cause flags
`timescale 1ns/100ps
`default_nettype none
`include "rtp_regs.svh"
module rtp_reset_seq #(
  parameter int PC_W  = 16,
  parameter int IW    = 16,
  parameter int RC_HZ = 32000,
  parameter int POWERUP_TIMER_W = 16
) (
  input  wire logic                      mclk,
  input  wire logic                      srst,
  input  wire logic                      ce,
  input  wire logic                      osc_input_pin,
  input  wire logic                      osc_valid,
  input  wire logic                      master_clear_n,
  input  wire logic                      por_detect,
  input  wire logic                      supply_ok,
  input  wire logic                      rc_slow_clk,
  input  wire rtp_pkg::rtp_osc_mode_type osc_mode,
  input  wire logic                      brownout_enable,
  input  wire logic                      ext_exec_mode,
  input  wire logic                      wdt_timeout,
  input  wire logic                      sleep_enter,
  input  wire logic                      wake_irq,
  input  wire logic                      clear_watchdog_instr,
  input  wire logic [1:0]                power_flag_set,
  input  wire logic                      branch_req,
  input  wire logic [PC_W-1:0]           branch_target,
  input  wire logic [IW-1:0]             instr_word,
  output var  rtp_pkg::rtp_phase_type    phase,
  output var  logic [PC_W-1:0]           program_counter,
  output var  logic [IW-1:0]             instruction_register,
  output var  logic                      exec_valid,
  output var  logic                      data_read_strobe,
  output var  logic                      data_write_strobe,
  output var  logic                      dev_reset,
  output var  logic                      core_hold,
  output var  logic                      ddr_force,
  output var  rtp_pkg::rtp_strobe_type   bus_strobes,
  output var  rtp_pkg::rtp_flags_type    cpu_status_reg
);
  // Power-up timer terminal count, rounded up to whole slow ticks
  localparam logic [POWERUP_TIMER_W-1:0] POWERUP_TIMER_TICKS =
    POWERUP_TIMER_W'((`RTP_POWERUP_TIMER_MS * RC_HZ + 999) / 1000);

  logic [5:0]                pin_s;
  logic                      osc_s, oscv_s, master_clear_n_s, por_s, sup_s, rc_s;
  logic                      osc_d_reg, rc_d_reg, osc_rise, rc_rise;
  rtp_pkg::rtp_state_type    st_reg, st_next;
  rtp_pkg::rtp_flags_type    fl_reg, fl_next;
  logic                      wake_rst_reg, wake_rst_next;
  logic [POWERUP_TIMER_W-1:0]         powerup_timer_reg, powerup_timer_next;
  logic [`RTP_OST_W-1:0]     ost_reg, ost_next;
  logic                      powerup_timer_done, ost_done, bor_trip, slow_osc;
  logic                      in_reset;
  rtp_pkg::rtp_phase_type    ph_reg, ph_next;
  logic [PC_W-1:0]           pc_reg, pc_next;
  logic [IW-1:0]             ir_reg, ir_next;
  logic                      ev_reg, ev_next, hold_inc_reg, hold_inc_next;
  logic                      ddr_reg, ddr_next, tick, take_branch;

  // All pins cross into mclk here before any use
  rtp_sync #(.W(6)) u_sync (
    .mclk (mclk),
    .srst (srst),
    .ce   (ce),
    .d    ({osc_input_pin, osc_valid, master_clear_n,
            por_detect, supply_ok, rc_slow_clk}),
    .q    (pin_s)
  );
  assign {osc_s, oscv_s, master_clear_n_s, por_s, sup_s, rc_s} = pin_s;

  // Edge detection on the synchronised pins
  assign osc_rise = osc_s & ~osc_d_reg;
  assign rc_rise  = rc_s & ~rc_d_reg;

  assign powerup_timer_done = (powerup_timer_reg == POWERUP_TIMER_TICKS);
  assign ost_done  = (ost_reg == `RTP_OST_PERIODS);
  assign bor_trip  = brownout_enable & ~sup_s;
  assign slow_osc  = (osc_mode == rtp_pkg::XT_CRYSTAL_MODE) ||
                     (osc_mode == rtp_pkg::LOW_FREQ_MODE);
  // Interrupt wake holds the core but is no reset
  assign in_reset  = (st_reg == rtp_pkg::RS_POR) ||
                     (st_reg == rtp_pkg::RS_MASTER_CLEAR_N_WAIT) ||
                     (st_reg == rtp_pkg::RS_TIMING) ||
                     (st_reg == rtp_pkg::RS_MASTER_CLEAR_N) ||
                     (st_reg == rtp_pkg::RS_WDT) ||
                     ((st_reg == rtp_pkg::RS_WAKE) && wake_rst_reg);
  assign core_hold = in_reset || (st_reg == rtp_pkg::RS_SLEEP) ||
                     (st_reg == rtp_pkg::RS_WAKE);

  // Reset sequence and cause flags; hardware events beat software sets
  always_comb begin
    st_next       = st_reg;
    fl_next       = fl_reg;
    wake_rst_next = wake_rst_reg;
    if (st_reg == rtp_pkg::RS_RUN) begin
      fl_next.power_on_flag = fl_reg.power_on_flag | power_flag_set[1];
      fl_next.brownout_flag = fl_reg.brownout_flag | power_flag_set[0];
    end
    if (!por_s) begin
      st_next = rtp_pkg::RS_POR;
      fl_next = `RTP_FLAGS_POR;
    end else if (bor_trip) begin
      st_next = rtp_pkg::RS_POR;
      fl_next.brownout_flag  = 1'b0;
      fl_next.timeout_flag   = 1'b1;
      fl_next.powerdown_flag = 1'b1;
    end else begin
      case (st_reg)
        rtp_pkg::RS_POR: begin
          if (master_clear_n_s) st_next = rtp_pkg::RS_TIMING;
          else st_next = rtp_pkg::RS_MASTER_CLEAR_N_WAIT;
        end
        rtp_pkg::RS_MASTER_CLEAR_N_WAIT: begin
          if (master_clear_n_s) st_next = rtp_pkg::RS_TIMING;
        end
        rtp_pkg::RS_TIMING: begin
          if (powerup_timer_done && ost_done) st_next = rtp_pkg::RS_RUN;
        end
        rtp_pkg::RS_RUN: begin
          if (!master_clear_n_s) begin
            st_next = rtp_pkg::RS_MASTER_CLEAR_N;
            wake_rst_next = 1'b0;
            fl_next.timeout_flag   = 1'b1;
            fl_next.powerdown_flag = 1'b1;
          end else if (wdt_timeout) begin
            st_next = rtp_pkg::RS_WDT;
            fl_next.timeout_flag   = 1'b0;
            fl_next.powerdown_flag = 1'b1;
          end else if (sleep_enter) begin
            st_next = rtp_pkg::RS_SLEEP;
            fl_next.timeout_flag   = 1'b1;
            fl_next.powerdown_flag = 1'b0;
          end else if (clear_watchdog_instr) begin
            fl_next.timeout_flag   = 1'b1;
            fl_next.powerdown_flag = 1'b1;
          end
        end
        rtp_pkg::RS_MASTER_CLEAR_N: begin
          if (master_clear_n_s && wake_rst_reg) st_next = rtp_pkg::RS_WAKE;
          else if (master_clear_n_s) st_next = rtp_pkg::RS_RUN;
        end
        rtp_pkg::RS_WDT: st_next = rtp_pkg::RS_RUN;
        rtp_pkg::RS_SLEEP: begin
          if (!master_clear_n_s) begin
            st_next = rtp_pkg::RS_MASTER_CLEAR_N;
            wake_rst_next = slow_osc;
            fl_next.timeout_flag   = 1'b1;
            fl_next.powerdown_flag = 1'b0;
          end else if (wdt_timeout) begin
            st_next = slow_osc ? rtp_pkg::RS_WAKE : rtp_pkg::RS_WDT;
            wake_rst_next = 1'b1;
            fl_next.timeout_flag   = 1'b0;
            fl_next.powerdown_flag = 1'b0;
          end else if (wake_irq) begin
            st_next = slow_osc ? rtp_pkg::RS_WAKE : rtp_pkg::RS_RUN;
            wake_rst_next = 1'b0;
          end
        end
        rtp_pkg::RS_WAKE: begin
          if (ost_done) st_next = rtp_pkg::RS_RUN;
        end
        default: st_next = rtp_pkg::RS_POR;
      endcase
    end
  end

  // Timers run side by side; start-up timer needs a valid oscillator
  always_comb begin
    powerup_timer_next = '0;
    ost_next  = '0;
    if (st_reg == rtp_pkg::RS_TIMING && !powerup_timer_done)
      powerup_timer_next = powerup_timer_reg + POWERUP_TIMER_W'(rc_rise);
    else if (st_reg == rtp_pkg::RS_TIMING)
      powerup_timer_next = powerup_timer_reg;
    if ((st_reg == rtp_pkg::RS_TIMING || st_reg == rtp_pkg::RS_WAKE) &&
        !ost_done)
      ost_next = ost_reg + `RTP_OST_W'(osc_rise & oscv_s);
    else if (st_reg == rtp_pkg::RS_TIMING || st_reg == rtp_pkg::RS_WAKE)
      ost_next = ost_reg;
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      st_reg       <= rtp_pkg::RS_POR;
      fl_reg       <= `RTP_FLAGS_POR;
      wake_rst_reg <= 1'b0;
      powerup_timer_reg     <= '0;
      ost_reg      <= '0;
      osc_d_reg    <= 1'b0;
      rc_d_reg     <= 1'b0;
    end else if (ce) begin
      st_reg       <= st_next;
      fl_reg       <= fl_next;
      wake_rst_reg <= wake_rst_next;
      powerup_timer_reg     <= powerup_timer_next;
      ost_reg      <= ost_next;
      osc_d_reg    <= osc_s;
      rc_d_reg     <= rc_s;
    end
  end

  // Phase generator and fetch/execute pipeline
  assign tick        = osc_rise && !core_hold;
  assign take_branch = tick && ph_reg == rtp_pkg::PH_FOUR &&
                       ev_reg && branch_req;
  always_comb begin
    ph_next       = ph_reg;
    pc_next       = pc_reg;
    ir_next       = ir_reg;
    ev_next       = ev_reg;
    hold_inc_next = hold_inc_reg;
    ddr_next      = in_reset;
    if (in_reset) begin
      pc_next       = `RTP_RESET_VECTOR;
      ev_next       = 1'b0;
      hold_inc_next = 1'b1;
    end
    if (core_hold) begin
      ph_next = rtp_pkg::PH_ONE;
    end else if (tick) begin
      ph_next = rtp_pkg::rtp_phase_type'(ph_reg + 2'h1);
      if (ph_reg == rtp_pkg::PH_ONE) begin
        if (!hold_inc_reg) pc_next = pc_reg + PC_W'(1);
        hold_inc_next = 1'b0;
      end
      if (take_branch) begin
        pc_next       = branch_target;
        hold_inc_next = 1'b1;
        ev_next       = 1'b0;
      end else if (ph_reg == rtp_pkg::PH_FOUR) begin
        ir_next = instr_word;
        ev_next = 1'b1;
      end
    end
  end

  // Instruction register has no reset, so its contents survive resets
  always_ff @(posedge mclk) begin
    if (ce) ir_reg <= ir_next;
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      ph_reg       <= rtp_pkg::PH_ONE;
      pc_reg       <= `RTP_RESET_VECTOR;
      ev_reg       <= 1'b0;
      hold_inc_reg <= 1'b1;
      ddr_reg      <= 1'b1;
    end else if (ce) begin
      ph_reg       <= ph_next;
      pc_reg       <= pc_next;
      ev_reg       <= ev_next;
      hold_inc_reg <= hold_inc_next;
      ddr_reg      <= ddr_next;
    end
  end

  // Strobes and outputs; bus pins released when not in reset
  always_comb begin
    bus_strobes = '0;
    if (in_reset && ext_exec_mode) begin
      bus_strobes.address_latch_strobe_oe = 1'b1;
      bus_strobes.output_enable_strobe_o  = 1'b1;
      bus_strobes.output_enable_strobe_oe = 1'b1;
      bus_strobes.write_strobe_o          = 1'b1;
      bus_strobes.write_strobe_oe         = 1'b1;
    end
  end
  assign data_read_strobe  = !core_hold && ev_reg &&
                             ph_reg == rtp_pkg::PH_TWO;
  assign data_write_strobe = !core_hold && ev_reg &&
                             ph_reg == rtp_pkg::PH_FOUR;
  assign phase                = ph_reg;
  assign program_counter      = pc_reg;
  assign instruction_register = ir_reg;
  assign exec_valid           = ev_reg;
  assign dev_reset            = in_reset;
  assign ddr_force            = ddr_reg;
  assign cpu_status_reg       = fl_reg;

  default clocking cb @(posedge mclk iff ce);
  endclocking
  default disable iff (srst);

  sequence branch_seen_s;
    take_branch;
  endsequence
  sequence flushed_s;
    !ev_reg && pc_reg == $past(branch_target);
  endsequence

  phase_hold_a: assert property (core_hold |=> ph_reg == rtp_pkg::PH_ONE)
    else $error("phase not held in phase one");
  ddr_set_a: assert property ($rose(in_reset) |=> ddr_force)
    else $error("direction force missing in reset");
  strobe_idle_a: assert property (in_reset && ext_exec_mode |->
    bus_strobes == 6'h1f)
    else $error("bus strobes wrong in reset");
  por_hold_a: assert property (!por_s |=> st_reg == rtp_pkg::RS_POR &&
    fl_reg == `RTP_FLAGS_POR)
    else $error("power-on reset state wrong");
  bor_flag_a: assert property (por_s && bor_trip |=>
    !fl_reg.brownout_flag && fl_reg.power_on_flag == $past(fl_reg.power_on_flag))
    else $error("brown-out flags wrong");
  timer_wait_a: assert property (st_reg == rtp_pkg::RS_TIMING && por_s &&
    !bor_trip && !(powerup_timer_done && ost_done) |=> in_reset)
    else $error("reset released before timers expired");
  ost_count_a: assert property (ost_reg != $past(ost_reg) && ost_reg != 0
    |-> $past(osc_rise && oscv_s))
    else $error("start-up timer counted without valid clock");
  master_clear_n_flags_a: assert property (st_reg == rtp_pkg::RS_RUN && por_s &&
    !bor_trip && !master_clear_n_s |=> fl_reg.timeout_flag && fl_reg.powerdown_flag)
    else $error("master clear flags wrong");
  wdt_flags_a: assert property (st_reg == rtp_pkg::RS_RUN && por_s &&
    !bor_trip && master_clear_n_s && wdt_timeout |=> !fl_reg.timeout_flag &&
    fl_reg.powerdown_flag)
    else $error("watchdog flags wrong");
  pc_vector_a: assert property (in_reset |=> pc_reg == `RTP_RESET_VECTOR)
    else $error("program counter not at vector");
  branch_flush_a: assert property (branch_seen_s |=> flushed_s)
    else $error("branch did not flush pipeline");
endmodule : rtp_reset_seq
`default_nettype wire

// *** shared/rtp_regs.svh ***
// Timing counts and reset values of the reset sequencer
`ifndef RTP_REGS_SVH
`define RTP_REGS_SVH
// Power-up timer nominal time, milliseconds
`define RTP_POWERUP_TIMER_MS      96
// Oscillator start-up timer length, oscillator periods
`define RTP_OST_PERIODS  11'h400
`define RTP_OST_W        11
// Reset vector loaded into the program counter
`define RTP_RESET_VECTOR 16'h0000
// Flag pattern after power-on: power_on, brownout, timeout, powerdown
`define RTP_FLAGS_POR    4'h3
`endif

// *** shared/rtp_pkg.sv ***
// Types shared by the reset sequencer
package rtp_pkg;
  typedef enum logic [1:0] {
    PH_ONE, PH_TWO, PH_THREE, PH_FOUR
  } rtp_phase_type;
  typedef enum logic [1:0] {
    XT_CRYSTAL_MODE, LOW_FREQ_MODE, EXT_CLOCK_MODE, RC_OSC_MODE
  } rtp_osc_mode_type;
  typedef enum logic [2:0] {
    RS_POR, RS_MASTER_CLEAR_N_WAIT, RS_TIMING, RS_RUN,
    RS_MASTER_CLEAR_N, RS_WDT, RS_SLEEP, RS_WAKE
  } rtp_state_type;
  // Reset cause flags, read by software
  typedef struct packed {
    logic power_on_flag;
    logic brownout_flag;
    logic timeout_flag;
    logic powerdown_flag;
  } rtp_flags_type;
  // External bus strobe pins, value and enable
  typedef struct packed {
    logic address_latch_strobe_o;
    logic address_latch_strobe_oe;
    logic output_enable_strobe_o;
    logic output_enable_strobe_oe;
    logic write_strobe_o;
    logic write_strobe_oe;
  } rtp_strobe_type;
endpackage : rtp_pkg

// *** core/rtp_sync.sv ***
// Two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/100ps
`default_nettype none
module rtp_sync #(
  parameter int W = 1
) (
  input  wire logic         mclk,
  input  wire logic         srst,
  input  wire logic         ce,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] meta_next;
  logic [W-1:0] q_next;

  // Only the second stage reads the first
  always_comb begin
    meta_next = d;
    q_next    = meta_reg;
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      meta_reg <= '0;
      q        <= '0;
    end else if (ce) begin
      meta_reg <= meta_next;
      q        <= q_next;
    end
  end
endmodule : rtp_sync
`default_nettype wire

// *** sim/rtp_pin_model.sv ***
// Oscillator source, slow RC clock and master clear pin driver
`timescale 1ns/100ps
`default_nettype none
module rtp_pin_model (
  input  wire logic        osc_on,
  input  wire logic        master_clear_n_hold,
  input  wire logic [15:0] rc_half,
  output var  logic        osc_input_pin,
  output var  logic        osc_valid,
  output var  logic        rc_slow_clk,
  output var  logic        master_clear_n
);
  int amp;
  // Pin has a pull-up, so a released pin reads high
  assign master_clear_n = ~master_clear_n_hold;
  // Crystal needs a few swings before the qualifier rises
  initial begin
    osc_input_pin = 1'h0;
    osc_valid = 1'h0;
    amp = 0;
    forever begin
      if (osc_on) begin
        osc_input_pin = 1'h1;
        #160;
        osc_input_pin = 1'h0;
        #160;
        amp = amp + 1;
        osc_valid = (amp > 3);
      end else begin
        amp = 0;
        osc_valid = 1'h0;
        #40;
      end
    end
  end
  // Free running RC clock, half period in bench cycles plus one
  initial begin
    rc_slow_clk = 1'h0;
    forever #((rc_half + 16'h1) * 40) rc_slow_clk = ~rc_slow_clk;
  end
endmodule : rtp_pin_model
`default_nettype wire

// *** sim/tb.sv ***
// Self-checking bench for the reset sequencer
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic mclk, srst, osc_on, master_clear_n_hold, por_detect, supply_ok;
  logic brownout_enable, ext_exec_mode, wdt_timeout, sleep_enter;
  logic wake_irq, clear_watchdog_instr, branch_req;
  logic osc_input_pin, osc_valid, rc_slow_clk, master_clear_n;
  logic exec_valid, data_read_strobe, data_write_strobe;
  logic dev_reset, core_hold, ddr_force;
  logic [1:0] power_flag_set;
  logic [15:0] branch_target, instr_word, program_counter;
  logic [15:0] instruction_register;
  logic [15:0] rc_half = 16'h15;
  rtp_pkg::rtp_osc_mode_type osc_mode;
  rtp_pkg::rtp_phase_type phase;
  rtp_pkg::rtp_strobe_type bus_strobes;
  rtp_pkg::rtp_flags_type cpu_status_reg;
  int err_count, compares;

  // Short power-up count: ten RC ticks instead of thousands
  rtp_reset_seq #(.RC_HZ(100)) DUT (.mclk, .srst, .ce(1'h1),
    .osc_input_pin, .osc_valid, .master_clear_n, .por_detect,
    .supply_ok, .rc_slow_clk, .osc_mode, .brownout_enable,
    .ext_exec_mode, .wdt_timeout, .sleep_enter, .wake_irq,
    .clear_watchdog_instr, .power_flag_set, .branch_req,
    .branch_target, .instr_word, .phase, .program_counter,
    .instruction_register, .exec_valid, .data_read_strobe,
    .data_write_strobe, .dev_reset, .core_hold, .ddr_force,
    .bus_strobes, .cpu_status_reg);
  rtp_pin_model pins (.osc_on, .master_clear_n_hold, .rc_half, .osc_input_pin,
    .osc_valid, .rc_slow_clk, .master_clear_n);

  // 25 MHz clock
  initial begin
    mclk = 1'h0;
    forever #20 mclk = ~mclk;
  end
  // Fake program memory: word tied to its address
  always @(posedge mclk) begin
    #2;
    instr_word = program_counter ^ 16'h5a5a;
  end
  // Hang guard, about twice the expected run
  initial begin
    #2400000;
    err_count++;
    results;
  end

  task cyc(input int n);
    repeat (n) @(posedge mclk);
    #2;
  endtask : cyc

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task results;
    if (err_count == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : results

  // Bounded wait for reset or hold to drop
  task wait_low(input logic hold, input int lim, output int n);
    n = 0;
    while ((hold ? core_hold : dev_reset) !== 1'h0 && n < lim) begin
      cyc(1);
      n++;
    end
  endtask : wait_low

  task chk_rst(input logic ext);
    rtp_pkg::rtp_strobe_type es;
    es = '0;
    if (ext) begin
      es.address_latch_strobe_oe = 1'h1;
      es.output_enable_strobe_o = 1'h1;
      es.output_enable_strobe_oe = 1'h1;
      es.write_strobe_o = 1'h1;
      es.write_strobe_oe = 1'h1;
    end
    chk(phase, rtp_pkg::PH_ONE);
    chk(ddr_force, 1'h1);
    chk(bus_strobes, es);
  endtask : chk_rst

  task t_por;
    int n;
    cyc(50);
    chk(dev_reset, 1'h1);
    chk(cpu_status_reg, 4'h3);
    chk_rst(1'h1);
    osc_on = 1'h1;
    por_detect = 1'h1;
    cyc(500);
    chk(dev_reset, 1'h1);
    master_clear_n_hold = 1'h0;
    wait_low(1'h0, 20000, n);
    chk(n >= 8100 && n < 8400, 1'h1);
    chk(program_counter, 16'h0);
    power_flag_set = 2'h3;
    cyc(1);
    power_flag_set = 2'h0;
    cyc(2);
    chk(cpu_status_reg, 4'hf);
  endtask : t_por

  task t_pipe;
    rtp_pkg::rtp_phase_type pp;
    logic [15:0] ppc;
    logic br, nob;
    br = 1'h0;
    nob = (phase == rtp_pkg::PH_ONE);
    pp = phase;
    ppc = program_counter;
    for (int i = 0; i < 400; i++) begin
      cyc(1);
      chk(data_read_strobe, exec_valid && phase == rtp_pkg::PH_TWO);
      chk(data_write_strobe, exec_valid && phase == rtp_pkg::PH_FOUR);
      if (phase != pp) begin
        chk(phase, 2'(pp + 2'h1));
        if (pp == rtp_pkg::PH_ONE) begin
          chk(program_counter, nob ? ppc : 16'(ppc + 16'h1));
          nob = 1'h0;
        end
        if (pp == rtp_pkg::PH_FOUR && br) begin
          chk(program_counter, 16'h1234);
          chk(exec_valid, 1'h0);
          br = 1'h0;
          branch_req = 1'h0;
          nob = 1'h1;
        end else if (pp == rtp_pkg::PH_FOUR) begin
          chk(instruction_register, ppc ^ 16'h5a5a);
          chk(exec_valid, 1'h1);
        end
        pp = phase;
      end
      ppc = program_counter;
      // Raised after the phase check so no earlier tick is blamed on it
      if (i == 200) begin
        branch_req = 1'h1;
        br = 1'h1;
      end
    end
  endtask : t_pipe

  task t_master_clear_n;
    logic [15:0] ir;
    int n;
    // Far from a load tick, so the word must survive untouched
    while (phase != rtp_pkg::PH_TWO) cyc(1);
    ir = instruction_register;
    master_clear_n_hold = 1'h1;
    cyc(5);
    chk_rst(1'h1);
    chk(cpu_status_reg, 4'hf);
    chk(program_counter, 16'h0);
    chk(instruction_register, ir);
    master_clear_n_hold = 1'h0;
    wait_low(1'h0, 40, n);
    chk(n < 40, 1'h1);
  endtask : t_master_clear_n

  task t_wdt;
    wdt_timeout = 1'h1;
    cyc(1);
    wdt_timeout = 1'h0;
    cyc(3);
    chk(cpu_status_reg, 4'hd);
    chk(program_counter, 16'h0);
    clear_watchdog_instr = 1'h1;
    cyc(1);
    clear_watchdog_instr = 1'h0;
    cyc(2);
    chk(cpu_status_reg, 4'hf);
  endtask : t_wdt

  task t_sleep;
    int n;
    logic [15:0] pc;
    osc_mode = rtp_pkg::EXT_CLOCK_MODE;
    sleep_enter = 1'h1;
    cyc(1);
    sleep_enter = 1'h0;
    cyc(5);
    chk(core_hold, 1'h1);
    master_clear_n_hold = 1'h1;
    cyc(5);
    chk(cpu_status_reg, 4'he);
    master_clear_n_hold = 1'h0;
    wait_low(1'h0, 40, n);
    chk(program_counter, 16'h0);
    sleep_enter = 1'h1;
    cyc(1);
    sleep_enter = 1'h0;
    cyc(5);
    wdt_timeout = 1'h1;
    cyc(1);
    wdt_timeout = 1'h0;
    cyc(3);
    chk(cpu_status_reg, 4'hc);
    wait_low(1'h0, 40, n);
    chk(program_counter, 16'h0);
    // Crystal mode: interrupt wake waits out the start-up count
    osc_mode = rtp_pkg::XT_CRYSTAL_MODE;
    sleep_enter = 1'h1;
    cyc(1);
    sleep_enter = 1'h0;
    cyc(5);
    pc = program_counter;
    wake_irq = 1'h1;
    cyc(1);
    wake_irq = 1'h0;
    wait_low(1'h1, 20000, n);
    chk(n >= 8100 && n < 8400, 1'h1);
    chk(cpu_status_reg, 4'he);
    chk(program_counter, pc);
  endtask : t_sleep

  task t_bor;
    int n;
    rc_half = 16'h1f4;
    ext_exec_mode = 1'h0;
    brownout_enable = 1'h1;
    supply_ok = 1'h0;
    cyc(5);
    supply_ok = 1'h1;
    cyc(5);
    chk_rst(1'h0);
    chk(cpu_status_reg, 4'hb);
    // Slow RC now makes the power-up count the longer one
    wait_low(1'h0, 15000, n);
    chk(n >= 9000 && n < 11000, 1'h1);
    chk(program_counter, 16'h0);
    por_detect = 1'h0;
    cyc(5);
    chk(dev_reset, 1'h1);
    chk(cpu_status_reg, 4'h3);
  endtask : t_bor

  // Main sequence
  initial begin
    srst = 1'h1;
    osc_on = 1'h0;
    master_clear_n_hold = 1'h1;
    por_detect = 1'h0;
    supply_ok = 1'h1;
    brownout_enable = 1'h0;
    ext_exec_mode = 1'h1;
    wdt_timeout = 1'h0;
    sleep_enter = 1'h0;
    wake_irq = 1'h0;
    clear_watchdog_instr = 1'h0;
    branch_req = 1'h0;
    branch_target = 16'h1234;
    power_flag_set = 2'h0;
    osc_mode = rtp_pkg::XT_CRYSTAL_MODE;
    err_count = 0;
    compares = 0;
    cyc(6);
    srst = 1'h0;
    t_por;
    t_pipe;
    t_master_clear_n;
    t_wdt;
    t_sleep;
    t_bor;
    results;
  end
endmodule : tb
`default_nettype wire
